/* File: inc/i2cbc_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the I2C master port.
`ifndef I2CBC_CFG_SVH
`define I2CBC_CFG_SVH
`define I2CBC_OFF_BUF 12'h000
`define I2CBC_OFF_CON2 12'h004
`define I2CBC_OFF_STAT 12'h008
`define I2CBC_OFF_RELOAD 12'h00C
`define I2CBC_OFF_FLAGS 12'h010
`define I2CBC_CON2_SEN 0
`define I2CBC_CON2_RSEN 1
`define I2CBC_CON2_PEN 2
`define I2CBC_CON2_ACKEN 4
`define I2CBC_CON2_ACKDT 5
`define I2CBC_CON2_ACKSTAT 6
`define I2CBC_STAT_BF 0
`define I2CBC_STAT_S 3
`define I2CBC_STAT_P 4
`define I2CBC_FLG_BCOL 0
`define I2CBC_FLG_SPIF 1
`define I2CBC_RELOAD_RST 7'h10
`endif

/* File: inc/i2cbc_pkg.sv */
// Types shared by the I2C master port with bus collision detection.
package i2cbc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_S_CHK = 4'h1,
    ST_S_HI = 4'h2,
    ST_S_LO = 4'h3,
    ST_R_SDA = 4'h4,
    ST_R_SCL = 4'h5,
    ST_R_HI = 4'h6,
    ST_R_LO = 4'h7,
    ST_P_SDA = 4'h8,
    ST_P_SCL = 4'h9,
    ST_P_HI = 4'hA,
    ST_P_CHK = 4'hB,
    ST_TX_LO = 4'hC,
    ST_TX_HI = 4'hD,
    ST_A_LO = 4'hE,
    ST_A_HI = 4'hF
  } i2cbc_state_t;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } i2cbc_drive_t;
endpackage : i2cbc_pkg

/* File: rtl/i2cbc_master.sv */
// I2C master port with multi-master arbitration and bus collision detection.
//
// Operation
// (R1) Released SDA expecting one but sampled low with SCL high: collision.
// (R2) Any collision sets collision flag and returns the port to idle.
// (R3) Collision in a byte: stop shifting, clear buffer full, release lines.
// (R4) Collision in start/restart/stop/ack: abort, release lines, clear enable bits.
// (R5) After collision keep monitoring; stop on bus sets port interrupt flag.
// (R6) A buffer write after collision sends from the first data bit.
// (R7) Start and stop seen on the bus raise the port interrupt flag.
// (R8) Software starts only when stop seen, or start and stop both clear; the port starts on sen_q without checking start_seen_q or stop_seen_q.
// (R9) Start with SDA or SCL already low: abort, flag collision, go idle.
// (R10) Start: with SDA high and lines released, load generator and count.
// (R11) SCL low while SDA high in first start count is a collision.
// (R12) SDA low in first start count: reset generator, drive SDA low early.
// (R13) SDA high to count end: drive SDA low, count again, then drive SCL low.
// (R14) Restart: release SDA, count, release SCL; SDA low when SCL high collides.
// (R15) Restart with SDA high: reload and count; SDA falling is no collision.
// (R16) Restart: SCL falling before timeout with SDA not driven is a collision.
// (R17) Restart timeout with both high: drive SDA low, count, drive SCL low.
// (R18) Stop: drive SDA low, release SCL when SDA low, count when SCL high.
// (R19) Stop: SDA low after count following SDA release is a collision.
// (R20) Stop: SCL low after release but before SDA rises is a collision.
// (R21) Released SCL pauses the generator until SCL reads high, then reloads.
// (R22) Collision flag stays until software clears it.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "i2cbc_cfg.svh"
module i2cbc_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection.
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  wire scl_hi = scl_sync_q[1];
  wire sda_hi = sda_sync_q[1];
  wire bus_start = scl_hi && scl_prev_q && sda_prev_q && !sda_hi;
  wire bus_stop = scl_hi && scl_prev_q && !sda_prev_q && sda_hi;
  wire scl_fell = scl_prev_q && !scl_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and APB decode. The slave answers in the access cycle.
  i2cbc_pkg::i2cbc_state_t state_q;
  i2cbc_pkg::i2cbc_state_t state_d;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [6:0] reload_q;
  logic [6:0] baud_cnt_q;
  logic buf_full_q;
  logic sen_q;
  logic rsen_q;
  logic pen_q;
  logic acken_q;
  logic ackdt_q;
  logic ackstat_q;
  logic start_seen_q;
  logic stop_seen_q;
  logic bus_collision_flag_q;
  logic serial_port_int_flag_q;
  i2cbc_pkg::i2cbc_drive_t drv_q;
  i2cbc_pkg::i2cbc_drive_t drv_d;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sel_buf = paddr == `I2CBC_OFF_BUF;
  wire sel_con2 = paddr == `I2CBC_OFF_CON2;
  wire sel_stat = paddr == `I2CBC_OFF_STAT;
  wire sel_reload = paddr == `I2CBC_OFF_RELOAD;
  wire sel_flags = paddr == `I2CBC_OFF_FLAGS;
  wire mapped = sel_buf || sel_con2 || sel_stat || sel_reload || sel_flags;
  wire idle = state_q == i2cbc_pkg::ST_IDLE;
  wire wr_buf = wr && sel_buf && idle;
  wire wr_con2 = wr && sel_con2 && idle;
  wire [31:0] rd_con2 = {25'h0, ackstat_q, ackdt_q, acken_q, 1'b0, pen_q, rsen_q, sen_q};
  wire [31:0] rd_stat = {27'h0, stop_seen_q, start_seen_q, 2'h0, buf_full_q};
  wire [31:0] rd_flags = {30'h0, serial_port_int_flag_q, bus_collision_flag_q};
  wire [31:0] rd_mux = sel_buf ? {24'h0, shift_q} :
                       sel_con2 ? rd_con2 :
                       sel_stat ? rd_stat :
                       sel_reload ? {25'h0, reload_q} :
                       sel_flags ? rd_flags : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator: counts down from the reload value; zero is a timeout.
  logic baud_load;
  wire baud_zero = baud_cnt_q == 7'h00;
  logic collide;
  logic byte_done;

  always_comb begin
    state_d = state_q;
    drv_d = drv_q;
    baud_load = 1'b0;
    collide = 1'b0;
    byte_done = 1'b0;
    case (state_q)
      i2cbc_pkg::ST_IDLE: begin
        if (sen_q) begin
          drv_d = '0;
          if (!sda_hi || !scl_hi) begin
            collide = 1'b1; // R9
          end else begin
            baud_load = 1'b1; // R10
            state_d = i2cbc_pkg::ST_S_CHK;
          end
        end else if (rsen_q) begin
          drv_d.sda_oe = 1'b0;
          baud_load = 1'b1;
          state_d = i2cbc_pkg::ST_R_SDA;
        end else if (pen_q) begin
          drv_d.sda_oe = 1'b1; // R18
          state_d = i2cbc_pkg::ST_P_SDA;
        end else if (acken_q) begin
          drv_d.scl_oe = 1'b1;
          drv_d.sda_oe = !ackdt_q;
          baud_load = 1'b1;
          state_d = i2cbc_pkg::ST_A_LO;
        end else if (buf_full_q) begin
          drv_d.scl_oe = 1'b1;
          drv_d.sda_oe = !shift_q[7];
          baud_load = 1'b1;
          state_d = i2cbc_pkg::ST_TX_LO;
        end
      end
      i2cbc_pkg::ST_S_CHK: begin
        if (!sda_hi) begin
          drv_d.sda_oe = 1'b1; // R12
          baud_load = 1'b1;
          state_d = i2cbc_pkg::ST_S_LO;
        end else if (!scl_hi) begin
          collide = 1'b1; // R11
        end else if (baud_zero) begin
          drv_d.sda_oe = 1'b1; // R13
          baud_load = 1'b1;
          state_d = i2cbc_pkg::ST_S_LO;
        end
      end
      i2cbc_pkg::ST_S_LO: begin
        if (baud_zero) begin
          drv_d.scl_oe = 1'b1; // R13
          state_d = i2cbc_pkg::ST_IDLE;
        end
      end
      i2cbc_pkg::ST_R_SDA: begin
        if (baud_zero) begin
          drv_d.scl_oe = 1'b0; // R14
          state_d = i2cbc_pkg::ST_R_SCL;
        end
      end
      i2cbc_pkg::ST_R_SCL: begin
        if (scl_hi) begin
          if (!sda_hi) begin
            collide = 1'b1; // R14
          end else begin
            baud_load = 1'b1; // R15
            state_d = i2cbc_pkg::ST_R_HI;
          end
        end
      end
      i2cbc_pkg::ST_R_HI: begin
        if (scl_fell) begin
          collide = 1'b1; // R16
        end else if (baud_zero) begin
          drv_d.sda_oe = 1'b1; // R17
          baud_load = 1'b1;
          state_d = i2cbc_pkg::ST_R_LO;
        end
      end
      i2cbc_pkg::ST_R_LO: begin
        if (baud_zero) begin
          drv_d.scl_oe = 1'b1; // R17
          state_d = i2cbc_pkg::ST_IDLE;
        end
      end
      i2cbc_pkg::ST_P_SDA: begin
        if (!sda_hi) begin
          drv_d.scl_oe = 1'b0; // R18
          state_d = i2cbc_pkg::ST_P_SCL;
        end
      end
      i2cbc_pkg::ST_P_SCL: begin
        if (scl_hi) begin
          baud_load = 1'b1; // R21
          state_d = i2cbc_pkg::ST_P_HI;
        end
      end
      i2cbc_pkg::ST_P_HI: begin
        if (!scl_hi) begin
          collide = 1'b1; // R20
        end else if (baud_zero) begin
          drv_d.sda_oe = 1'b0;
          baud_load = 1'b1;
          state_d = i2cbc_pkg::ST_P_CHK;
        end
      end
      i2cbc_pkg::ST_P_CHK: begin
        if (baud_zero) begin
          if (!sda_hi) begin
            collide = 1'b1; // R19
          end else begin
            state_d = i2cbc_pkg::ST_IDLE;
          end
        end
      end
      i2cbc_pkg::ST_TX_LO, i2cbc_pkg::ST_A_LO: begin
        if (baud_zero) begin
          drv_d.scl_oe = 1'b0;
          state_d = (state_q == i2cbc_pkg::ST_TX_LO) ? i2cbc_pkg::ST_TX_HI
                                                     : i2cbc_pkg::ST_A_HI;
        end
      end
      i2cbc_pkg::ST_TX_HI: begin
        if (scl_hi && !drv_q.sda_oe && !sda_hi && bit_cnt_q != 4'h8) begin
          collide = 1'b1; // R1
        end else if (scl_hi && baud_zero && scl_prev_q) begin
          drv_d.scl_oe = 1'b1;
          baud_load = 1'b1;
          if (bit_cnt_q == 4'h8) begin
            byte_done = 1'b1;
            state_d = i2cbc_pkg::ST_IDLE;
          end else begin
            drv_d.sda_oe = (bit_cnt_q == 4'h7) ? 1'b0 : !shift_q[6];
            state_d = i2cbc_pkg::ST_TX_LO;
          end
        end
      end
      i2cbc_pkg::ST_A_HI: begin
        if (scl_hi && !drv_q.sda_oe && !sda_hi) begin
          collide = 1'b1; // R1
        end else if (scl_hi && baud_zero && scl_prev_q) begin
          drv_d.scl_oe = 1'b1;
          state_d = i2cbc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = i2cbc_pkg::ST_IDLE;
      end
    endcase
    if (collide) begin
      drv_d = '0; // R3 R4
      state_d = i2cbc_pkg::ST_IDLE; // R2
    end
  end

  // A released SCL holds the count at its reload value until the line reads high.
  wire scl_wait = !drv_q.scl_oe && !scl_hi;
  wire tx_hi_edge = (state_q == i2cbc_pkg::ST_TX_HI || state_q == i2cbc_pkg::ST_A_HI)
                    && scl_hi && !scl_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // State, baud generator and shifter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= i2cbc_pkg::ST_IDLE;
      drv_q <= '0;
      baud_cnt_q <= 7'h00;
    end else begin
      state_q <= state_d;
      drv_q <= drv_d;
      if (baud_load || scl_wait || tx_hi_edge) begin
        baud_cnt_q <= reload_q; // R10 R21
      end else if (!baud_zero) begin
        baud_cnt_q <= baud_cnt_q - 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      buf_full_q <= 1'b0;
      ackstat_q <= 1'b0;
    end else if (collide) begin
      buf_full_q <= 1'b0; // R3
      bit_cnt_q <= 4'h0;
    end else if (wr_buf) begin
      shift_q <= pwdata[7:0];
      bit_cnt_q <= 4'h0; // R6
      buf_full_q <= 1'b1;
    end else if (state_q == i2cbc_pkg::ST_TX_HI && state_d == i2cbc_pkg::ST_TX_LO) begin
      shift_q <= {shift_q[6:0], 1'b0};
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q == 4'h7) begin
        buf_full_q <= 1'b0;
      end
    end else if (byte_done) begin
      ackstat_q <= sda_hi;
      bit_cnt_q <= 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control enables and flags; a hardware set wins over a software clear.
  wire seq_end = !idle && state_d == i2cbc_pkg::ST_IDLE;
  wire flag_clr = wr && sel_flags;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_q <= 1'b0;
      rsen_q <= 1'b0;
      pen_q <= 1'b0;
      acken_q <= 1'b0;
      ackdt_q <= 1'b0;
      reload_q <= `I2CBC_RELOAD_RST;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
      bus_collision_flag_q <= 1'b0;
      serial_port_int_flag_q <= 1'b0;
    end else begin
      if (collide || seq_end) begin
        sen_q <= 1'b0; // R4
        rsen_q <= 1'b0;
        pen_q <= 1'b0;
        acken_q <= 1'b0;
      end else if (wr_con2) begin
        sen_q <= pwdata[`I2CBC_CON2_SEN];
        rsen_q <= pwdata[`I2CBC_CON2_RSEN];
        pen_q <= pwdata[`I2CBC_CON2_PEN];
        acken_q <= pwdata[`I2CBC_CON2_ACKEN];
        ackdt_q <= pwdata[`I2CBC_CON2_ACKDT];
      end
      if (wr && sel_reload) begin
        reload_q <= pwdata[6:0];
      end
      if (bus_start) begin
        start_seen_q <= 1'b1; // R7
        stop_seen_q <= 1'b0;
      end else if (bus_stop) begin
        stop_seen_q <= 1'b1; // R5 R7
        start_seen_q <= 1'b0;
      end
      if (collide) begin
        bus_collision_flag_q <= 1'b1; // R2
      end else if (flag_clr && pwdata[`I2CBC_FLG_BCOL]) begin
        bus_collision_flag_q <= 1'b0; // R22
      end
      if (bus_start || bus_stop || byte_done) begin
        serial_port_int_flag_q <= 1'b1; // R5 R7
      end else if (flag_clr && pwdata[`I2CBC_FLG_SPIF]) begin
        serial_port_int_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer and pin outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(mapped);
      prdata <= (psel && !penable) ? rd_mux : 32'h0;
      scl_oe <= drv_d.scl_oe;
      sda_oe <= drv_d.sda_oe;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

endmodule : i2cbc_master

/* File: sim/i2cbc_partner.sv */
// Model of another master on the shared bus, pulling lines low on its own 64 ns clock.
`timescale 1ns/1ns
module i2cbc_partner (
  input logic hold_sda,
  input logic hold_scl,
  output logic scl_pull,
  output logic sda_pull
);
  logic lclk;
  ////////////////////////////////////////////////////////////////////////////////
  // The foreign master is never in phase with the port, so pulls move on its own clock.
  initial begin
    lclk = 1'b0;
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    #5;
    forever #32 lclk = ~lclk;
  end
  always @(posedge lclk) begin
    scl_pull <= hold_scl;
    sda_pull <= hold_sda;
  end
endmodule : i2cbc_partner

/* File: sim/i2cbc_monitor.sv */
// Checker of the APB answers and the pin drive of the I2C master port.
`timescale 1ns/1ns
`include "i2cbc_cfg.svh"
module i2cbc_monitor (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic scl_i,
  input logic scl_o,
  input logic scl_oe,
  input logic sda_i,
  input logic sda_o,
  input logic sda_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire mapped = paddr == `I2CBC_OFF_BUF || paddr == `I2CBC_OFF_CON2 ||
    paddr == `I2CBC_OFF_STAT || paddr == `I2CBC_OFF_RELOAD || paddr == `I2CBC_OFF_FLAGS;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_setup: assert property (s_setup |=> s_access) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_unmapped: assert property (psel && !penable && !mapped |=> pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped address refused");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_pins_low: assert property (!scl_o && !sda_o) else $error("pin driven high");
  // A released clock stays released for at least four cycles before it is pulled again.
  a_scl_high: assert property ($fell(scl_oe) |-> !scl_oe [*4])
    else $error("clock pulled low too soon");
endmodule : i2cbc_monitor
bind i2cbc_master i2cbc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

/* File: sim/tb.sv */
// Testbench of the I2C master port: registers, start, byte, restart, stop and collisions.
`timescale 1ns/1ns
`include "i2cbc_cfg.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic hold_sda = 1'b0;
  logic hold_scl = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, p_scl, p_sda;
  wire scl = ~(scl_oe | p_scl);
  wire sda = ~(sda_oe | p_sda);
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic slv_err;
  logic [7:0] bits;
  always #4 pclk = ~pclk;
  i2cbc_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe));
  i2cbc_partner peer (.hold_sda(hold_sda), .hold_scl(hold_scl), .scl_pull(p_scl),
    .sda_pull(p_sda));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic guard(inout int n);
    n++;
    if (n > 4000) begin
      check("wait bound", 32'h1, 32'h0);
      end_sim();
    end
  endtask : guard
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      guard(n);
      @(posedge pclk);
    end
    rd = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd & m, exp);
  endtask : rchk
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while ((rd & m) !== v) begin
      guard(n);
      apb(1'b0, a, 32'h0);
    end
    check("poll", rd & m, v);
  endtask : poll
  // The foreign master pulls one line part way into a sequence; the port must give up.
  task automatic lose(input logic [31:0] en, input int dly, input logic on_sda);
    apb(1'b1, `I2CBC_OFF_CON2, en);
    repeat (dly) @(posedge pclk);
    if (on_sda) begin
      hold_sda <= 1'b1;
    end else begin
      hold_scl <= 1'b1;
    end
    poll(`I2CBC_OFF_FLAGS, 32'h1, 32'h1);
    rchk("enable dropped", `I2CBC_OFF_CON2, en, 32'h0);
    check("lines let go", {30'h0, scl_oe, sda_oe}, 32'h0);
    apb(1'b1, `I2CBC_OFF_FLAGS, 32'h3);
    hold_sda <= 1'b0;
    hold_scl <= 1'b0;
    repeat (20) @(posedge pclk);
  endtask : lose
  task automatic wait_scl(input logic v);
    int n;
    n = 0;
    while (scl !== v) begin
      guard(n);
      @(posedge pclk);
    end
  endtask : wait_scl
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk("reload reset", `I2CBC_OFF_RELOAD, 32'hFFFFFFFF, 32'h10);
    rchk("flags reset", `I2CBC_OFF_FLAGS, 32'hFFFFFFFF, 32'h0);
    rchk("status reset", `I2CBC_OFF_STAT, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check("unmapped error", {31'h0, slv_err}, 32'h1);
    apb(1'b1, `I2CBC_OFF_RELOAD, 32'h83);
    rchk("reload field", `I2CBC_OFF_RELOAD, 32'hFFFFFFFF, 32'h3);
    // A foreign master holds SDA low, so the start must give up at once.
    hold_sda <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b1, `I2CBC_OFF_CON2, 32'h1);
    poll(`I2CBC_OFF_FLAGS, 32'h1, 32'h1);
    rchk("start enable", `I2CBC_OFF_CON2, 32'h1, 32'h0);
    check("lines freed", {30'h0, scl_oe, sda_oe}, 32'h0);
    rchk("flag held", `I2CBC_OFF_FLAGS, 32'h1, 32'h1);
    apb(1'b1, `I2CBC_OFF_FLAGS, 32'h3);
    rchk("flag cleared", `I2CBC_OFF_FLAGS, 32'h1, 32'h0);
    // A byte of ones loses against the zeros of the other master.
    apb(1'b1, `I2CBC_OFF_BUF, 32'hFF);
    poll(`I2CBC_OFF_FLAGS, 32'h1, 32'h1);
    rchk("buffer full", `I2CBC_OFF_STAT, 32'h1, 32'h0);
    check("byte lines freed", {30'h0, scl_oe, sda_oe}, 32'h0);
    apb(1'b1, `I2CBC_OFF_FLAGS, 32'h3);
    hold_sda <= 1'b0;
    poll(`I2CBC_OFF_FLAGS, 32'h2, 32'h2);
    rchk("stop seen", `I2CBC_OFF_STAT, 32'h10, 32'h10);
    apb(1'b1, `I2CBC_OFF_FLAGS, 32'h3);
    apb(1'b1, `I2CBC_OFF_CON2, 32'h1);
    poll(`I2CBC_OFF_CON2, 32'h1, 32'h0);
    rchk("start clean", `I2CBC_OFF_FLAGS, 32'h1, 32'h0);
    rchk("start seen", `I2CBC_OFF_STAT, 32'h8, 32'h8);
    check("start drives", {30'h0, scl_oe, sda_oe}, 32'h3);
    apb(1'b1, `I2CBC_OFF_FLAGS, 32'h3);
    apb(1'b1, `I2CBC_OFF_BUF, 32'hA5);
    for (int i = 7; i >= 0; i--) begin
      wait_scl(1'b1);
      bits[i] = sda;
      wait_scl(1'b0);
    end
    check("byte bits", {24'h0, bits}, 32'hA5);
    poll(`I2CBC_OFF_FLAGS, 32'h2, 32'h2);
    rchk("no ack", `I2CBC_OFF_CON2, 32'h40, 32'h40);
    apb(1'b1, `I2CBC_OFF_CON2, 32'h10);
    poll(`I2CBC_OFF_CON2, 32'h10, 32'h0);
    rchk("ack clean", `I2CBC_OFF_FLAGS, 32'h1, 32'h0);
    apb(1'b1, `I2CBC_OFF_CON2, 32'h2);
    poll(`I2CBC_OFF_CON2, 32'h2, 32'h0);
    rchk("restart clean", `I2CBC_OFF_FLAGS, 32'h1, 32'h0);
    apb(1'b1, `I2CBC_OFF_CON2, 32'h4);
    poll(`I2CBC_OFF_CON2, 32'h4, 32'h0);
    rchk("stop clean", `I2CBC_OFF_FLAGS, 32'h1, 32'h0);
    rchk("stop seen end", `I2CBC_OFF_STAT, 32'h10, 32'h10);
    // A long count leaves room for the foreign master to act inside each sequence.
    apb(1'b1, `I2CBC_OFF_RELOAD, 32'h7F);
    lose(32'h1, 40, 1'b0);
    lose(32'h2, 200, 1'b0);
    lose(32'h4, 40, 1'b0);
    lose(32'h2, 40, 1'b1);
    lose(32'h4, 40, 1'b1);
    // A foreign master now holds SCL low before the start.
    hold_scl <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b1, `I2CBC_OFF_CON2, 32'h1);
    poll(`I2CBC_OFF_FLAGS, 32'h1, 32'h1);
    rchk("start aborted", `I2CBC_OFF_CON2, 32'h1, 32'h0);
    end_sim();
  end
endmodule : tb
